// ### pkg/pmi_pkg.sv
// Shared constants, modes and carrier types of the MAC data interface.
package pmi_pkg;

   // Interface mode select, one mode active at a time
   typedef enum logic [1:0] {
      PMI_MODE_MII = 2'b00,
      PMI_MODE_RMII = 2'b01,
      PMI_MODE_SERIAL = 2'b10
   } pmi_mode_e;

   // Unit taken from the MAC transmit pins on one clock tick
   typedef struct packed {
      logic en;
      logic [3:0] bits;
   } pmi_tx_unit_s;

   // Receive side pin bundle toward the MAC
   typedef struct packed {
      logic dv;
      logic er;
      logic crs;
      logic col;
      logic [3:0] rxd;
   } pmi_rx_pins_s;

   // Unit offered by the media side for one receive tick
   typedef struct packed {
      logic carrier;
      logic dv;
      logic err;
      logic [3:0] bits;
   } pmi_rx_unit_s;

   // System clock rate and derived interface clock divisors
   localparam int CLK_MHZ = 250;
   localparam int MII100_MHZ = 25;
   localparam int MII10_KHZ = 2500;
   localparam int SERIAL_MHZ = 10;
   localparam int RMII_REF_MHZ = 50;
   localparam logic [6:0] DIV_MII100 = 7'(CLK_MHZ / MII100_MHZ);
   localparam logic [6:0] DIV_MII10 = 7'((CLK_MHZ * 1000) / MII10_KHZ);
   localparam logic [6:0] DIV_SERIAL = 7'(CLK_MHZ / SERIAL_MHZ);
   localparam logic [6:0] DIV_RMII = 7'(CLK_MHZ / RMII_REF_MHZ);

   // Heartbeat pulse length, a longest time so it rounds down
   localparam int HB_NS = 1000;
   localparam logic [8:0] HB_CYC = 9'((HB_NS * CLK_MHZ) / 1000);

   // Register offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_COLCNT = 4'h8;

   // Control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SPEED100 = 2;
   localparam int CTRL_FULLDPX = 3;
   localparam int CTRL_HB_EN = 4;
   localparam logic [4:0] CTRL_RESET = 5'h14;

   // Status register fields
   localparam int STAT_TX_ACT = 0;
   localparam int STAT_CARRIER = 1;
   localparam int STAT_COL = 2;
   localparam int STAT_RX_DV = 3;
   localparam int STAT_HB = 4;

endpackage

// ### logic/pmi_mac_data_if.sv
// MAC-facing data interface of a 10/100 transceiver: MII, RMII and serial modes.
`timescale 1ns/1ps
`default_nettype none
module pmi_mac_data_if (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // MAC transmit pins
   input wire logic mac_tx_en,
   input wire logic [3:0] mac_txd,
   output logic tx_clk_o,
   // MAC receive pins
   output logic rx_clk_o,
   output pmi_pkg::pmi_rx_pins_s rx_pins,
   // Media side transmit stream
   output logic med_tx_strobe,
   output pmi_pkg::pmi_tx_unit_s med_tx_unit,
   // Media side receive stream
   input wire pmi_pkg::pmi_rx_unit_s med_rx_unit,
   output logic med_rx_take
);

   // Control fields held by software
   logic [4:0] ctrl_reg;
   pmi_pkg::pmi_mode_e mode;
   logic speed100;
   logic full_dpx;
   logic hb_en;

   // Interface clock divider
   logic [6:0] div_cnt_reg;
   logic [6:0] div_period;
   logic [6:0] div_hi_len;
   logic tick;
   logic fall_tick;
   logic clk_hi;

   // Transmit pin synchroniser and captured unit
   pmi_pkg::pmi_tx_unit_s tx_sync1_reg;
   pmi_pkg::pmi_tx_unit_s tx_sync2_reg;
   pmi_pkg::pmi_tx_unit_s tx_unit_reg;
   logic tx_strobe_reg;

   // Receive pins and media handshake
   pmi_pkg::pmi_rx_pins_s rx_pins_reg;
   pmi_pkg::pmi_rx_pins_s rx_pins_next;
   logic rx_take_reg;

   // Interface clock outputs
   logic tx_clk_reg;
   logic rx_clk_reg;

   // Collision and heartbeat
   logic tx_act_prev_reg;
   logic [8:0] hb_cnt_reg;
   logic hb_active;
   logic col_live;

   // Collision counter and read data
   logic [15:0] col_cnt_reg;
   logic col_prev_reg;
   logic [31:0] rdata_reg;

   // Control decode
   // Mode code 3 never reaches the register, see the write below
   assign mode = pmi_pkg::pmi_mode_e'(ctrl_reg[pmi_pkg::CTRL_MODE_LSB +: 2]);
   assign speed100 = ctrl_reg[pmi_pkg::CTRL_SPEED100];
   assign full_dpx = ctrl_reg[pmi_pkg::CTRL_FULLDPX];
   assign hb_en = ctrl_reg[pmi_pkg::CTRL_HB_EN];

   // Control register write; a reserved mode code is ignored
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Comes up in MII, 100 Mb/s, half duplex, heartbeat on
         ctrl_reg <= pmi_pkg::CTRL_RESET;
      end else if (reg_wr && reg_addr == pmi_pkg::OFS_CTRL) begin
         // Mode code 3 names no mode, so keep the old one
         if (reg_wdata[pmi_pkg::CTRL_MODE_LSB +: 2] != 2'b11) begin
            ctrl_reg <= reg_wdata[4:0];
         end else begin
            ctrl_reg <= {reg_wdata[4:2], ctrl_reg[1:0]};
         end
      end
   end

   // Divider period for the active mode and speed
   always_comb begin
      case (mode)
         // MII: 25 MHz at 100 Mb/s, 2.5 MHz at 10 Mb/s
         pmi_pkg::PMI_MODE_MII: begin
            div_period = speed100 ? pmi_pkg::DIV_MII100 : pmi_pkg::DIV_MII10;
         end
         // RMII: local 50 MHz reference timing for both directions
         pmi_pkg::PMI_MODE_RMII: begin
            div_period = pmi_pkg::DIV_RMII;
         end
         // Serial: 10 MHz for both clocks
         pmi_pkg::PMI_MODE_SERIAL: begin
            div_period = pmi_pkg::DIV_SERIAL;
         end
         default: begin
            div_period = pmi_pkg::DIV_MII100;
         end
      endcase
   end

   // High phase takes the odd cycle when the period is odd
   assign div_hi_len = div_period - (div_period >> 1);

   // Tick is the last count of the period; the unit it captures shows at the wrap,
   // one cycle before the registered clock pins rise
   assign tick = (div_cnt_reg == div_period - 7'h01);

   // Receive pins change one cycle before the clock pins fall,
   // half a period away from the MAC's rising sample point
   assign fall_tick = (div_cnt_reg == div_hi_len - 7'h01);
   assign clk_hi = (div_cnt_reg < div_hi_len);

   // Free-running divider; a mode change mid-count just wraps early
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_reg <= 7'h00;
      end else if (tick || div_cnt_reg >= div_period) begin
         // End of period, or at once after a switch to a shorter period
         div_cnt_reg <= 7'h00;
      end else begin
         // Count up through the period
         div_cnt_reg <= div_cnt_reg + 7'h01;
      end
   end

   // Clock pins; both idle low in RMII mode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Both clock pins start low
         tx_clk_reg <= 1'b0;
         rx_clk_reg <= 1'b0;
      end else if (mode == pmi_pkg::PMI_MODE_RMII) begin
         tx_clk_reg <= 1'b0;
         rx_clk_reg <= 1'b0;
      end else begin
         // The receive clock stands in for the recovered line clock
         tx_clk_reg <= clk_hi;
         rx_clk_reg <= clk_hi;
      end
   end

   // Clock pins leave straight from flops, so decode glitches never reach the MAC
   assign tx_clk_o = tx_clk_reg;
   assign rx_clk_o = rx_clk_reg;

   // Two-flop synchroniser on the asynchronous MAC transmit pins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Pins read as idle during reset
         tx_sync1_reg <= '0;
         tx_sync2_reg <= '0;
      end else begin
         // Only the second stage feeds any logic
         tx_sync1_reg <= {mac_tx_en, mac_txd};
         tx_sync2_reg <= tx_sync1_reg;
      end
   end

   // Capture one unit per tick; the MAC keeps enable high over valid data
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_unit_reg <= '0;
         tx_strobe_reg <= 1'b0;
      end else if (tick) begin
         tx_unit_reg.en <= tx_sync2_reg.en;
         tx_strobe_reg <= 1'b1;
         // Lane width follows the mode; unused lanes pass as zero
         case (mode)
            pmi_pkg::PMI_MODE_MII: begin
               tx_unit_reg.bits <= tx_sync2_reg.bits;
            end
            pmi_pkg::PMI_MODE_RMII: begin
               tx_unit_reg.bits <= {2'b00, tx_sync2_reg.bits[1:0]};
            end
            pmi_pkg::PMI_MODE_SERIAL: begin
               tx_unit_reg.bits <= {3'b000, tx_sync2_reg.bits[0]};
            end
            default: begin
               // Reserved mode: nothing valid to pass
               tx_unit_reg.bits <= 4'h0;
            end
         endcase
      end else begin
         // Strobe lasts one cycle
         tx_strobe_reg <= 1'b0;
      end
   end

   // The unit stands a full period; the strobe marks its first cycle
   assign med_tx_strobe = tx_strobe_reg;
   assign med_tx_unit = tx_unit_reg;

   // Live collision: both directions busy, half duplex, not RMII
   // Reduced mode has no collision pin; its MAC works collision out itself
   assign col_live = tx_unit_reg.en && med_rx_unit.carrier && !full_dpx
                     && mode != pmi_pkg::PMI_MODE_RMII;

   // Heartbeat is active while its counter runs
   assign hb_active = (hb_cnt_reg != 9'h000);

   // Heartbeat: one pulse after each transmission in 10 Mb half duplex, MII or serial mode only
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // No pulse pending after reset
         tx_act_prev_reg <= 1'b0;
         hb_cnt_reg <= 9'h000;
      end else begin
         tx_act_prev_reg <= tx_unit_reg.en;
         if (full_dpx || speed100 || mode == pmi_pkg::PMI_MODE_RMII) begin
            // No heartbeat outside 10 Mb half duplex
            hb_cnt_reg <= 9'h000;
         end else if (tx_act_prev_reg && !tx_unit_reg.en && hb_en) begin
            // A falling enable marks the end of a transmission
            hb_cnt_reg <= pmi_pkg::HB_CYC;
         end else if (hb_active) begin
            // Count down to the end of the pulse
            hb_cnt_reg <= hb_cnt_reg - 9'h001;
         end
      end
   end

   // Receive pin values for the active mode
   always_comb begin
      rx_pins_next = '0;
      // Pins unused in a mode keep this zero default
      case (mode)
         // MII: nibble data, valid flag, error only at 100 Mb/s
         pmi_pkg::PMI_MODE_MII: begin
            rx_pins_next.dv = med_rx_unit.dv;
            rx_pins_next.er = med_rx_unit.err && med_rx_unit.dv && speed100;
            rx_pins_next.crs = med_rx_unit.carrier;
            // Corrupt by inversion so a MAC without the error pin sees a bad check
            rx_pins_next.rxd = med_rx_unit.err ? ~med_rx_unit.bits
                               : med_rx_unit.bits;
            if (!med_rx_unit.dv) begin
               rx_pins_next.rxd = 4'h0;
            end
         end
         // RMII: two bits, separate valid, combined carrier/valid on the carrier pin
         pmi_pkg::PMI_MODE_RMII: begin
            rx_pins_next.dv = med_rx_unit.dv;
            rx_pins_next.er = med_rx_unit.err && med_rx_unit.dv && speed100;
            // Simplified: high while carrier or data remain
            rx_pins_next.crs = med_rx_unit.carrier || med_rx_unit.dv;
            rx_pins_next.rxd[1:0] = med_rx_unit.err ? ~med_rx_unit.bits[1:0]
                                    : med_rx_unit.bits[1:0];
            if (!med_rx_unit.dv) begin
               rx_pins_next.rxd[1:0] = 2'b00;
            end
         end
         // Serial: bit 0 framed by carrier; valid and error pins idle
         pmi_pkg::PMI_MODE_SERIAL: begin
            rx_pins_next.crs = med_rx_unit.carrier;
            rx_pins_next.rxd[0] = med_rx_unit.carrier && med_rx_unit.bits[0];
         end
         default: begin
            rx_pins_next = '0;
         end
      endcase
      // Collision pin: live overlap or heartbeat, never in full duplex
      rx_pins_next.col = col_live || hb_active;
   end

   // Receive pins other than collision update once per interface clock, one cycle before its falling edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // Pins idle low during reset
         rx_pins_reg <= '0;
         rx_take_reg <= 1'b0;
      end else if (fall_tick) begin
         // A new unit once per period
         rx_pins_reg <= rx_pins_next;
         rx_take_reg <= 1'b1;
      end else begin
         // Collision follows without waiting for the next unit
         rx_pins_reg.col <= col_live || hb_active;
         rx_take_reg <= 1'b0;
      end
   end

   // Receive pins leave straight from flops toward the MAC
   assign rx_pins = rx_pins_reg;
   assign med_rx_take = rx_take_reg;

   // Collision events counted on the rising edge of the collision pin
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         col_prev_reg <= 1'b0;
         col_cnt_reg <= 16'h0000;
      end else begin
         col_prev_reg <= rx_pins_reg.col;
         if (reg_wr && reg_addr == pmi_pkg::OFS_COLCNT) begin
            // Clearing loses an event landing in the same cycle; counts are advisory
            col_cnt_reg <= 16'h0000;
         end else if (rx_pins_reg.col && !col_prev_reg && col_cnt_reg != 16'hffff) begin
            // Count each new collision, holding at the top value
            col_cnt_reg <= col_cnt_reg + 16'h0001;
         end
      end
   end

   // Register read, data one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg <= 32'h0000_0000;
      end else if (reg_rd) begin
         // Clear first so unused bits read as zero
         rdata_reg <= 32'h0000_0000;
         case (reg_addr)
            pmi_pkg::OFS_CTRL: begin
               rdata_reg[4:0] <= ctrl_reg;
            end
            pmi_pkg::OFS_STATUS: begin
               rdata_reg[pmi_pkg::STAT_TX_ACT] <= tx_unit_reg.en;
               rdata_reg[pmi_pkg::STAT_CARRIER] <= rx_pins_reg.crs;
               rdata_reg[pmi_pkg::STAT_COL] <= rx_pins_reg.col;
               rdata_reg[pmi_pkg::STAT_RX_DV] <= rx_pins_reg.dv;
               rdata_reg[pmi_pkg::STAT_HB] <= hb_active;
            end
            pmi_pkg::OFS_COLCNT: begin
               rdata_reg[15:0] <= col_cnt_reg;
            end
            default: begin
               // Unmapped offset reads zero
               rdata_reg <= 32'h0000_0000;
            end
         endcase
      end else begin
         // Read data stands only in the cycle after the strobe
         rdata_reg <= 32'h0000_0000;
      end
   end

   // Read data from a flop, zero outside its one cycle
   assign reg_rdata = rdata_reg;

endmodule // pmi_mac_data_if
`default_nettype wire

// ### sim/pmi_mac_data_if_checker.sv
// Concurrent checks on the MAC data interface ports.
`timescale 1ns/1ps
`default_nettype none
module pmi_mac_data_if_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Register writes
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   // Interface clocks and receive pins
   input wire logic tx_clk_o,
   input wire logic rx_clk_o,
   input wire pmi_pkg::pmi_rx_pins_s rx_pins,
   // Media side
   input wire logic med_tx_strobe,
   input wire pmi_pkg::pmi_tx_unit_s med_tx_unit,
   input wire pmi_pkg::pmi_rx_unit_s med_rx_unit,
   input wire logic med_rx_take
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [4:0] ctl_reg; // Shadow of the control register
   logic [8:0] age_reg; // Cycles since the last control write, saturating
   logic [6:0] gap_reg; // Cycles since the last transmit tick
   logic [6:0] per; // Tick period expected for the shadow setting
   logic s; // Long enough after a write for dividers and heartbeat to settle
   logic rm; // Reduced mode active
   logic hb; // Heartbeat expected after each frame
   logic wr_ctl; // Control write this cycle
   assign wr_ctl = reg_wr && reg_addr == pmi_pkg::OFS_CTRL;
   assign s = &age_reg;
   assign rm = ctl_reg[1:0] == pmi_pkg::PMI_MODE_RMII;
   assign hb = s && !rm && ctl_reg[4] && !ctl_reg[3] && !ctl_reg[2];
   assign per = rm ? pmi_pkg::DIV_RMII : ctl_reg[1] ? pmi_pkg::DIV_SERIAL :
      ctl_reg[2] ? pmi_pkg::DIV_MII100 : pmi_pkg::DIV_MII10;
   // Shadow control; a mode field of 3 is refused so the old mode stays
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctl_reg <= pmi_pkg::CTRL_RESET;
      end else if (wr_ctl) begin
         ctl_reg[4:2] <= reg_wdata[4:2];
         if (reg_wdata[1:0] != 2'b11) begin
            ctl_reg[1:0] <= reg_wdata[1:0];
         end
      end
   end
   // Settling age, restarted by any control write
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         age_reg <= 9'h0;
      end else if (wr_ctl) begin
         age_reg <= 9'h0;
      end else if (!s) begin
         age_reg <= age_reg + 9'h1;
      end
   end
   // Tick spacing counter
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         gap_reg <= 7'h0;
      end else begin
         gap_reg <= med_tx_strobe ? 7'h1 : gap_reg + 7'h1;
      end
   end
   chk_tick_period: assert property (s && med_tx_strobe |-> gap_reg == per)
      else $error("transmit tick spacing wrong");
   chk_clk_strobe: assert property (s && !rm |-> $past(med_tx_strobe) == $rose(tx_clk_o))
      else $error("transmit clock edge and tick apart");
   chk_rx_phase: assert property (s && !rm |-> rx_clk_o == tx_clk_o)
      else $error("receive clock off phase");
   chk_rmii_idle: assert property (s && rm |-> !tx_clk_o && !rx_clk_o && !rx_pins.col)
      else $error("clock or collision pin active in reduced mode");
   chk_take_fall: assert property (s && !rm && med_rx_take |-> ##1 $fell(rx_clk_o))
      else $error("receive update off the falling clock");
   chk_rx_stand: assert property (s && !med_rx_take |->
      $stable({rx_pins.dv, rx_pins.er, rx_pins.crs, rx_pins.rxd}))
      else $error("receive pins moved between units");
   chk_col_fdx: assert property (s && ctl_reg[3] |-> !rx_pins.col)
      else $error("collision in full duplex");
   chk_col_overlap: assert property (s && !rm && !ctl_reg[3] && ctl_reg[2] |->
      rx_pins.col == $past(med_tx_unit.en && med_rx_unit.carrier))
      else $error("collision not tied to overlap");
   chk_hb_pulse: assert property (hb && $fell(med_tx_unit.en) |->
      ##2 rx_pins.col ##249 rx_pins.col ##1 !rx_pins.col)
      else $error("heartbeat pulse length wrong");
endmodule // pmi_mac_data_if_checker
bind pmi_mac_data_if pmi_mac_data_if_checker u_pmi_mac_data_if_checker (.clk(clk),
   .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .tx_clk_o(tx_clk_o), .rx_clk_o(rx_clk_o), .rx_pins(rx_pins),
   .med_tx_strobe(med_tx_strobe), .med_tx_unit(med_tx_unit),
   .med_rx_unit(med_rx_unit), .med_rx_take(med_rx_take));
`default_nettype wire

// ### sim/pmi_mac_model.sv
// Behavioural MAC transmit side, paced by the block's interface tick.
`timescale 1ns/1ps
`default_nettype none
module pmi_mac_model (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Frame request
   input wire logic go,
   input wire logic [7:0] go_len,
   // Block timing and carrier
   input wire logic med_tx_strobe,
   input wire logic rx_crs,
   // MAC pins
   output logic mac_tx_en,
   output logic [3:0] mac_txd,
   output logic mac_col,
   output logic busy
);
   logic [7:0] left_reg; // Units still to send
   logic more; // A unit remains
   assign more = left_reg != 8'h0;
   // Pins move just after a tick, so they are settled long before the next capture;
   // between frames data flips so a stale value is never mistaken for a fresh one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         left_reg <= 8'h0;
         mac_tx_en <= 1'b0;
         mac_txd <= 4'h0;
      end else if (go) begin
         left_reg <= go_len;
      end else if (med_tx_strobe) begin
         mac_tx_en <= more;
         mac_txd <= more ? mac_txd + 4'h7 : ~mac_txd;
         left_reg <= more ? left_reg - 8'h1 : 8'h0;
      end
   end
   assign busy = more || mac_tx_en;
   // Reduced mode has no collision pin: the MAC combines carrier with its own enable
   assign mac_col = mac_tx_en && rx_crs;
endmodule // pmi_mac_model
`default_nettype wire

// ### sim/pmi_mac_data_if_test.sv
// Self-checking bench for the MAC data interface across all its modes.
`timescale 1ns/1ps
`default_nettype none
module pmi_mac_data_if_test;
   logic clk, nrst, reg_wr, reg_rd, go, mac_tx_en, med_tx_strobe, med_rx_take;
   logic tx_clk_o, rx_clk_o, busy, rx_on, watch;
   logic [3:0] reg_addr, mac_txd, msk;
   logic [31:0] reg_wdata, reg_rdata;
   logic [6:0] got; // Receive pins less collision
   logic [4:0] cur; // Setting last written
   pmi_pkg::pmi_rx_pins_s rx_pins;
   pmi_pkg::pmi_tx_unit_s med_tx_unit;
   pmi_pkg::pmi_rx_unit_s med_rx_unit = '0;
   int num_errors, n_tests, n, hb_cnt;
   assign got = {rx_pins.dv, rx_pins.er, rx_pins.crs, rx_pins.rxd};
   assign msk = cur[1:0] == 2'b01 ? 4'h3 : cur[1] ? 4'h1 : 4'hf;
   pmi_mac_data_if u_pmi_mac_data_if (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .tx_clk_o(tx_clk_o), .rx_clk_o(rx_clk_o),
      .rx_pins(rx_pins), .med_tx_strobe(med_tx_strobe), .med_tx_unit(med_tx_unit),
      .med_rx_unit(med_rx_unit), .med_rx_take(med_rx_take));
   pmi_mac_model u_pmi_mac_model (.clk(clk), .nrst(nrst), .go(go), .go_len(8'h0c),
      .med_tx_strobe(med_tx_strobe), .rx_crs(rx_pins.crs), .mac_tx_en(mac_tx_en),
      .mac_txd(mac_txd), .mac_col(), .busy(busy));
   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Pins the block should show for a taken unit; errors invert the data
   function automatic logic [6:0] rx_exp(input logic [4:0] c, input pmi_pkg::pmi_rx_unit_s u);
      logic [3:0] d;
      d = u.dv ? (u.err ? ~u.bits : u.bits) : 4'h0;
      case (c[1:0])
         2'b01: rx_exp = {u.dv, u.err & u.dv & c[2], u.carrier | u.dv, 2'b00, d[1:0]};
         2'b10: rx_exp = {3'b001 & {2'b00, u.carrier}, 3'b000, u.carrier & u.bits[0]};
         default: rx_exp = {u.dv, u.err & u.dv & c[2], u.carrier, d};
      endcase
   endfunction
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // One-cycle write strobe
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 check("register read", reg_rdata, exp);
   endtask
   // Each tick the captured unit must be what the MAC held over the last period
   always @(posedge clk) begin
      if (watch && med_tx_strobe === 1'b1) begin
         check("tx enable", med_tx_unit.en, mac_tx_en);
         if (mac_tx_en) check("tx bits", med_tx_unit.bits, mac_txd & msk);
      end
   end
   // Judge each delivered unit, then offer the next; each setting restarts the odd step from zero and ends before it walks all unit values
   always @(posedge clk) begin
      if (med_rx_take === 1'b1) begin
         if (watch) check("rx pins", got, rx_exp(cur, med_rx_unit));
         med_rx_unit <= rx_on ? med_rx_unit + 7'h0b : 7'h00;
      end
   end
   // One setting: settle, send a frame against live receive traffic, then count heartbeat
   task automatic run_cfg(input logic [4:0] c);
      reg_write(pmi_pkg::OFS_CTRL, {27'h0, c});
      cur = c;
      reg_read(pmi_pkg::OFS_CTRL, {27'h0, c});
      repeat (520) @(posedge clk);
      #1 watch = 1'b1;
      rx_on = 1'b1;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      n = 0;
      #1 while ((busy || med_tx_unit.en !== 1'b0) && n < 3000) begin
         @(posedge clk);
         #1 n++;
      end
      if (n >= 3000) begin
         num_errors++;
         conclude();
      end
      hb_cnt = 0;
      repeat (300) begin
         @(posedge clk);
         #1 hb_cnt += (rx_pins.col === 1'b1);
      end
      // Only 10 Mb half duplex with heartbeat on, outside reduced mode, pulses
      check("heartbeat", hb_cnt, (c[4:2] == 3'b100 && c[1:0] != 2'b01) ? pmi_pkg::HB_CYC : 0);
      watch = 1'b0;
      rx_on = 1'b0;
      $display("Setting %h done, mismatches %0d", c, num_errors);
   endtask
   // Main sequence
   initial begin
      nrst = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      go = 1'b0;
      rx_on = 1'b0;
      watch = 1'b0;
      cur = pmi_pkg::CTRL_RESET;
      num_errors = 0;
      n_tests = 0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      reg_read(pmi_pkg::OFS_CTRL, 32'h14);
      reg_read(pmi_pkg::OFS_COLCNT, 32'h0);
      reg_read(4'hc, 32'h0);
      // Mode 3 is refused; the other bits still land
      reg_write(pmi_pkg::OFS_CTRL, 32'h1f);
      reg_read(pmi_pkg::OFS_CTRL, 32'h1c);
      $display("Register test done, mismatches %0d", num_errors);
      run_cfg(5'h14);
      run_cfg(5'h10);
      run_cfg(5'h05);
      run_cfg(5'h01);
      run_cfg(5'h12);
      run_cfg(5'h1c);
      // Any write clears the collision count
      reg_write(pmi_pkg::OFS_COLCNT, 32'h1);
      reg_read(pmi_pkg::OFS_COLCNT, 32'h0);
      // Idle line after the last setting: every status flag low
      repeat (30) @(posedge clk);
      reg_read(pmi_pkg::OFS_STATUS, 32'h0);
      conclude();
   end
endmodule // pmi_mac_data_if_test
`default_nettype wire
